/* File: lss_regs.vh */
// timing, scaling and state constants for the led soft-start sequencer
`ifndef LSS_REGS_VH
`define LSS_REGS_VH
`define LSS_CLK_MHZ 100
`define LSS_TSS_US 2000
`define LSS_TSS_CYC (`LSS_TSS_US * `LSS_CLK_MHZ)
`define LSS_STEPS 15
`define LSS_STEP_CYC (`LSS_TSS_CYC / `LSS_STEPS)
`define LSS_TFAULT_US 10000
`define LSS_TFAULT_CYC (`LSS_TFAULT_US * `LSS_CLK_MHZ)
`define LSS_REF_W 9
`define LSS_REF_FULL 9'h12C
`define LSS_REF_STEP 9'h014
`define LSS_EXT_FLOOR 9'h03F
`define LSS_ST_IDLE 2'h0
`define LSS_ST_RAMP 2'h1
`define LSS_ST_DONE 2'h2
`endif

/* File: lss_soft_start.v */
// soft-start sequencer with dimming on-time extension
//
// Function
// [RULE1] arm soft start on first dimming rising edge or first pwm engine cycle
// [RULE2] run soft start at start-up and after sense, feedback, thermal, supply faults
// [RULE3] short to ground starts soft start and repeats it every fault retry period
// [RULE4] step reference from zero to full scale in 15 steps over ramp time
// [RULE5] with analog adjustment, clamp steps at adjusted target and hold it
// [RULE6] start extension if pulse ends in ramp time with sense below extension ref
// [RULE7] extension keeps switching on until sense reaches extension reference
// [RULE8] extension reference follows adjustment down, never below fixed floor
// [RULE9] for first three steps extension reference exceeds stepped reference
// [RULE10] adjusted reference below floor: extension ends when ramp time elapses
// [RULE11] extension ending early retriggers on next pwm cycle if sense low again
// [RULE12] after extension, steps advance only during later dimming on times
// [RULE13] current loop always on; voltage loop takes over at feedback reference
// [RULE14] steps advance at equal intervals of ramp time divided by step count
`timescale 1ns/10ps
`default_nettype none
`include "lss_regs.vh"
module lss_soft_start #(
  parameter [31:0] TSS_CYC = `LSS_TSS_CYC,
  parameter [31:0] STEP_CYC = `LSS_STEP_CYC,
  parameter [31:0] TFAULT_CYC = `LSS_TFAULT_CYC
) (
  // clock and reset
  input wire i_sys_clk,
  input wire i_resetn,
  // dimming sources
  input wire i_dimming_input,
  input wire i_engine_cycle,
  // fault flags
  input wire i_sense_high_ov,
  input wire i_voltage_feedback_ov,
  input wire i_overtemp,
  input wire i_internal_supply_uv,
  input wire i_short_to_ground,
  // comparators and analog adjustment
  input wire i_sense_below_ext,
  input wire i_vloop_enable,
  input wire i_feedback_at_ref,
  input wire [`LSS_REF_W-1:0] i_adjusted_ref,
  // outputs
  output reg [`LSS_REF_W-1:0] o_ref_code,
  output reg [`LSS_REF_W-1:0] o_extension_reference,
  output reg o_switch_gate_output,
  output reg o_extension_active,
  output reg o_soft_start_active,
  output reg o_current_loop_en,
  output reg o_voltage_mode
);
  localparam ST_IDLE = `LSS_ST_IDLE;
  localparam ST_RAMP = `LSS_ST_RAMP;
  localparam ST_DONE = `LSS_ST_DONE;
  localparam NSYNC = 9;

  // two-flop synchronisers for every pin input except i_vloop_enable and i_adjusted_ref
  wire [NSYNC-1:0] pins_in = {i_dimming_input, i_engine_cycle, i_sense_high_ov,
    i_voltage_feedback_ov, i_overtemp, i_internal_supply_uv, i_short_to_ground,
    i_sense_below_ext, i_feedback_at_ref};
  reg [NSYNC-1:0] meta_r;
  reg [NSYNC-1:0] sync_r;
  reg [NSYNC-1:0] sync_d_r;
  genvar g;
  generate
    for (g = 0; g < NSYNC; g = g + 1) begin : g_sync
      always @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          meta_r[g] <= 1'b0;
          sync_r[g] <= 1'b0;
          sync_d_r[g] <= 1'b0;
        end else begin
          meta_r[g] <= pins_in[g];
          sync_r[g] <= meta_r[g];
          sync_d_r[g] <= sync_r[g];
        end
      end
    end
  endgenerate

  // rising edge seen between the last two synchroniser stages
  function edge_up;
    input cur;
    input prev;
    begin
      edge_up = cur & ~prev;
    end
  endfunction

  wire dim_on = sync_r[8];
  wire dim_rise = edge_up(sync_r[8], sync_d_r[8]);
  wire dim_fall = edge_up(sync_d_r[8], sync_r[8]);
  wire eng_rise = edge_up(sync_r[7], sync_d_r[7]);
  wire hold_fault = |sync_r[6:3];
  wire short_rise = edge_up(sync_r[2], sync_d_r[2]);
  wire short_on = sync_r[2];
  wire below_ext = sync_r[1];
  wire fb_at_ref = sync_r[0];

  function [`LSS_REF_W-1:0] min_ref;
    input [`LSS_REF_W-1:0] a;
    input [`LSS_REF_W-1:0] b;
    begin
      min_ref = (a < b) ? a : b;
    end
  endfunction

  // target after adjustment, never above full scale
  wire [`LSS_REF_W-1:0] target = min_ref(i_adjusted_ref, `LSS_REF_FULL);
  // 0.8 of target, floored
  wire [`LSS_REF_W+2:0] target_x4 = {1'b0, target, 2'b00};
  // quotient never exceeds 240, so the low bits carry all of it
  wire [`LSS_REF_W+2:0] ext_quot = target_x4 / 12'h005;
  wire [`LSS_REF_W-1:0] ext_scaled = ext_quot[`LSS_REF_W-1:0];
  wire [`LSS_REF_W-1:0] ext_ref_nxt = (ext_scaled < `LSS_EXT_FLOOR) ?
    `LSS_EXT_FLOOR : ext_scaled; // [RULE8] [RULE9]
  wire adj_below_floor = target < `LSS_EXT_FLOOR;

  reg [1:0] state_r;
  reg armed_r;
  reg [3:0] step_r;
  reg [31:0] step_cnt_r;
  reg [31:0] tss_cnt_r;
  reg [31:0] retry_cnt_r;
  reg ext_r;
  wire tss_done = (tss_cnt_r >= TSS_CYC);
  wire retry_hit = short_on && (retry_cnt_r >= TFAULT_CYC - 32'h0000_0001);
  wire restart = hold_fault | short_rise | retry_hit; // [RULE2] [RULE3]
  wire first_cycle = dim_rise | eng_rise;

  // extension start and end conditions
  wire ext_start = (state_r == ST_RAMP) && !ext_r && dim_fall && !tss_done &&
    below_ext; // [RULE6] [RULE11]
  wire ext_stop = ext_r && (!below_ext || (adj_below_floor && tss_done)); // [RULE7] [RULE10]

  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_r <= ST_IDLE;
      armed_r <= 1'b0;
      step_r <= 4'h0;
      step_cnt_r <= 32'h0000_0000;
      tss_cnt_r <= 32'h0000_0000;
      retry_cnt_r <= 32'h0000_0000;
      ext_r <= 1'b0;
    end else begin
      retry_cnt_r <= (short_on && !retry_hit) ? retry_cnt_r + 32'h0000_0001 :
        32'h0000_0000; // [RULE3]
      if (first_cycle) begin
        armed_r <= 1'b1;
      end
      if (restart) begin
        state_r <= ST_IDLE;
        step_r <= 4'h0;
        step_cnt_r <= 32'h0000_0000;
        tss_cnt_r <= 32'h0000_0000;
        ext_r <= 1'b0;
      end else begin
        case (state_r)
          ST_IDLE: begin
            if (armed_r || first_cycle) begin
              state_r <= ST_RAMP; // [RULE1] [RULE2]
            end
          end
          ST_RAMP: begin
            if (!tss_done) begin
              tss_cnt_r <= tss_cnt_r + 32'h0000_0001;
            end
            if (ext_start) begin
              ext_r <= 1'b1;
            end else if (ext_stop) begin
              ext_r <= 1'b0;
            end
            // steps run only while switching is allowed
            if (dim_on || ext_r) begin // [RULE12]
              if (step_cnt_r >= STEP_CYC - 32'h0000_0001) begin // [RULE14]
                step_cnt_r <= 32'h0000_0000;
                if (step_r == 4'd14) begin
                  state_r <= ST_DONE;
                  ext_r <= 1'b0;
                end
                step_r <= step_r + 4'h1; // [RULE4]
              end else begin
                step_cnt_r <= step_cnt_r + 32'h0000_0001;
              end
            end
          end
          ST_DONE: begin
            ext_r <= 1'b0;
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // 15 steps of 20 end exactly at full scale, no overflow in 9 bits
  wire [`LSS_REF_W-1:0] step_ref = {5'h00, step_r} * `LSS_REF_STEP;
  // extension start keeps the gate on in the cycle the pulse ends
  wire gate_nxt = (state_r != ST_IDLE) && (dim_on || ext_r || ext_start); // [RULE7]

  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_ref_code <= 9'h000;
      o_extension_reference <= `LSS_EXT_FLOOR;
      o_switch_gate_output <= 1'b0;
      o_extension_active <= 1'b0;
      o_soft_start_active <= 1'b0;
      o_current_loop_en <= 1'b0;
      o_voltage_mode <= 1'b0;
    end else begin
      o_ref_code <= (state_r == ST_IDLE) ? 9'h000 : min_ref(step_ref, target); // [RULE5]
      o_extension_reference <= ext_ref_nxt; // [RULE8]
      o_switch_gate_output <= gate_nxt; // [RULE7]
      o_extension_active <= ext_r;
      o_soft_start_active <= (state_r == ST_RAMP);
      o_current_loop_en <= 1'b1; // [RULE13]
      o_voltage_mode <= i_vloop_enable && fb_at_ref; // [RULE13]
    end
  end
endmodule
`default_nettype wire

/* File: lss_soft_start_properties.sv */
// concurrent checks on the soft-start sequencer ports
`timescale 1ns/10ps
`default_nettype none
module lss_soft_start_properties (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // inputs
  input wire logic i_sense_high_ov,
  input wire logic i_voltage_feedback_ov,
  input wire logic i_overtemp,
  input wire logic i_internal_supply_uv,
  input wire logic i_sense_below_ext,
  input wire logic i_vloop_enable,
  input wire logic [8:0] i_adjusted_ref,
  // outputs
  input wire logic [8:0] o_ref_code,
  input wire logic [8:0] o_extension_reference,
  input wire logic o_switch_gate_output,
  input wire logic o_extension_active,
  input wire logic o_soft_start_active,
  input wire logic o_current_loop_en,
  input wire logic o_voltage_mode
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  a_ext_floor: assert property (o_extension_reference >= 9'h03F)
    else $error("extension reference below floor");
  a_ext_track: assert property ($past(i_resetn) && $stable(i_adjusted_ref) [*3] |->
    o_extension_reference == (i_adjusted_ref < 79 ? 63 : i_adjusted_ref * 4 / 5))
    else $error("extension reference not tracking target");
  a_ref_max: assert property (o_ref_code <= 9'h12C)
    else $error("reference above full scale");
  a_ref_step: assert property (o_ref_code > $past(o_ref_code) |->
    o_ref_code - $past(o_ref_code) <= 9'h014)
    else $error("reference step too large");
  a_early_steps: assert property (o_ref_code <= 9'h03C |->
    o_extension_reference > o_ref_code)
    else $error("extension reference not above early step");
  a_fault_zero: assert property ((i_sense_high_ov || i_voltage_feedback_ov || i_overtemp ||
    i_internal_supply_uv) [*5] |-> o_ref_code == 0 && !o_soft_start_active)
    else $error("reference not held at zero in fault");
  a_ext_gate: assert property (o_extension_active && $past(o_extension_active) |->
    o_switch_gate_output)
    else $error("gate off during extension");
  a_ext_sense: assert property (!i_sense_below_ext [*6] |-> !o_extension_active)
    else $error("extension active with sense above reference");
  a_loop_on: assert property ($past(i_resetn) |-> o_current_loop_en)
    else $error("current loop disabled");
  a_vmode_cause: assert property (o_voltage_mode |-> $past(i_vloop_enable))
    else $error("voltage mode without voltage loop enable");
endmodule
`default_nettype wire

/* File: lss_sense_model.sv */
// sensed current model: rises while gate is on, collapses when off
`timescale 1ns/10ps
`default_nettype none
module lss_sense_model (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // regulator side
  input wire logic i_gate,
  input wire logic i_slow,
  input wire logic [8:0] i_cap,
  input wire logic [8:0] i_level,
  // comparator
  output logic o_below
);
  logic [8:0] v_r;
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn || !i_gate) v_r <= 9'h000;
    else if (v_r < i_cap) v_r <= v_r + (i_slow ? 9'h001 : 9'h008);
  end
  assign o_below = v_r < i_level;
endmodule
`default_nettype wire

/* File: lss_soft_start_test.sv */
// self-checking bench for the led soft-start sequencer
`timescale 1ns/10ps
`default_nettype none
module lss_soft_start_test;
  logic clk = 0, rstn = 0, dim = 0, eng = 0, sgnd = 0, vl = 0, fb = 0, slow = 0, below, p;
  logic gate, ext, ss, cl, vm;
  logic [3:0] flt = 0;
  logic [8:0] adj = 9'h12C, cap = 9'h1F0, ref_c, ext_ref, r;
  logic [8:0] rows [0:3][0:1] = '{'{9'h12C, 9'h0F0}, '{9'h064, 9'h050},
    '{9'h04E, 9'h03F}, '{9'h050, 9'h040}};
  int err_total = 0, checks_done = 0, cyc = 0, n;
  lss_soft_start #(.TSS_CYC(300), .STEP_CYC(20), .TFAULT_CYC(500)) lss_soft_start_inst (
    .i_sys_clk(clk), .i_resetn(rstn), .i_dimming_input(dim), .i_engine_cycle(eng),
    .i_sense_high_ov(flt[0]), .i_voltage_feedback_ov(flt[1]), .i_overtemp(flt[2]),
    .i_internal_supply_uv(flt[3]), .i_short_to_ground(sgnd), .i_sense_below_ext(below),
    .i_vloop_enable(vl), .i_feedback_at_ref(fb), .i_adjusted_ref(adj),
    .o_ref_code(ref_c), .o_extension_reference(ext_ref), .o_switch_gate_output(gate),
    .o_extension_active(ext), .o_soft_start_active(ss), .o_current_loop_en(cl),
    .o_voltage_mode(vm));
  lss_sense_model lss_sense_model_inst (.i_sys_clk(clk), .i_resetn(rstn), .i_gate(gate),
    .i_slow(slow), .i_cap(cap), .i_level(ext_ref), .o_below(below));
  initial begin
    forever #5 clk = ~clk;
  end
  task w(input int k);
    repeat (k) @(posedge clk);
  endtask
  task chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wrap_up;
    if (err_total == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 10000) begin
      err_total++;
      wrap_up;
    end
  end
  initial begin
    w(3);
    chk("ext_ref", 9'h03F, ext_ref);
    rstn <= 1;
    for (n = 0; n < 4; n++) begin
      adj <= rows[n][0];
      w(6);
      chk("ext_ref", rows[n][1], ext_ref);
    end
    chk("gate", 0, gate);
    adj <= 9'h12C;
    dim <= 1;
    w(8);
    chk("ss", 1, ss);
    w(340);
    chk("ref", 9'h12C, ref_c);
    chk("loop", 1, cl);
    adj <= 9'h064;
    for (n = 0; n < 4; n++) begin
      flt[n] <= 1;
      w(6);
      chk("ref", 0, ref_c);
      flt[n] <= 0;
      w(340);
      chk("ref", 9'h064, ref_c);
    end
    flt[0] <= 1;
    dim <= 0;
    slow <= 1;
    w(6);
    flt[0] <= 0;
    for (n = 0; n < 2; n++) begin
      w(4);
      dim <= 1;
      w(6);
      dim <= 0;
      w(5);
      chk("ext", 1, ext);
      chk("gate", 1, gate);
      w(120);
      chk("ext", 0, ext);
      r = ref_c;
      w(20);
      chk("ref", r, ref_c);
    end
    vl <= 1;
    fb <= 1;
    w(6);
    chk("vmode", 1, vm);
    vl <= 0;
    w(3);
    chk("vmode", 0, vm);
    dim <= 1;
    sgnd <= 1;
    n = 0;
    p = 1;
    repeat (1100) begin
      @(posedge clk);
      if (ss && !p) n++;
      p = ss;
    end
    chk("retry", 1, n >= 2);
    // second reset: arm from the pwm engine, sense held below the floor
    rstn <= 0;
    sgnd <= 0;
    dim <= 0;
    adj <= 9'h028;
    cap <= 9'h028;
    w(3);
    rstn <= 1;
    w(6);
    chk("ss", 0, ss);
    eng <= 1;
    w(6);
    chk("ss", 1, ss);
    w(50);
    dim <= 1;
    w(6);
    dim <= 0;
    w(5);
    chk("ext", 1, ext);
    w(200);
    chk("ext", 1, ext);
    w(50);
    chk("ext", 0, ext);
    wrap_up;
  end
endmodule
bind lss_soft_start lss_soft_start_properties lss_soft_start_properties_inst (
  .i_sys_clk(i_sys_clk),
  .i_resetn(i_resetn),
  .i_sense_high_ov(i_sense_high_ov),
  .i_voltage_feedback_ov(i_voltage_feedback_ov),
  .i_overtemp(i_overtemp),
  .i_internal_supply_uv(i_internal_supply_uv),
  .i_sense_below_ext(i_sense_below_ext),
  .i_vloop_enable(i_vloop_enable),
  .i_adjusted_ref(i_adjusted_ref),
  .o_ref_code(o_ref_code),
  .o_extension_reference(o_extension_reference),
  .o_switch_gate_output(o_switch_gate_output),
  .o_extension_active(o_extension_active),
  .o_soft_start_active(o_soft_start_active),
  .o_current_loop_en(o_current_loop_en),
  .o_voltage_mode(o_voltage_mode));
`default_nettype wire
